// ---- core/tlic_top.sv ----
// Two-level interrupt collector: flags, enables, summaries, request lines.
// Register port is a plain strobe bus with a fixed one-cycle read latency.
// Assumes event strobes from the DDC engines, converter, timer and mute
// logic are one-cycle pulses on clk; ext0, ext1 and vsync are raw pins.
`timescale 1ns/1ps
// Behaviour
// - DDC1 scl-low or start flags, enters DDC2
// - DDC2 own address called sets address flag
// - DDC2 transmit, holding empty sets flag
// - DDC2 receive, new byte sets flag
// - Transmit byte without acknowledge sets flag
// - Slave mode stop condition sets flag
// - All enables cleared after reset
// - Enables written per bit, read back
// - Enabled ext0 edge raises non-maskable request
// - Flags set regardless of enable state
// - Vsync pulse sets vsync flag, third group
// - Group summary set when member flagged
// - Group summary clears when members clear
// - Non-maskable pair follows same procedure
// - Flags stay until cleared, reinterrupt
// - Write one clears flag, zero keeps
// - Edge sources, select resets to all ones
// - Cleared select bit means falling edge
// - Third group: conversion, vsync, ext1, tick
// - Non-maskable request uses its own vector
module tlic_top
    import tlic_pkg::*;
(
    // Clock, reset and clock enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // Register port
    input wire logic [AW-1:0] busAddr,
    input wire logic [DW-1:0] busWrData,
    input wire logic busWrStb,
    input wire logic busRdStb,
    output logic [DW-1:0] busRdData,
    // External pins
    input wire logic ext0Pin,
    input wire logic ext1Pin,
    input wire logic vsyncPin,
    // Same-clock event strobes
    input wire logic autoMuteEv,
    input wire logic convDoneEv,
    input wire logic baseTickEv,
    // DDC engine events, one bit per channel; called and own addresses SLV_AW bits per channel
    input wire logic [DDC_CH-1:0] ddcSclLow,
    input wire logic [DDC_CH-1:0] ddcStart,
    input wire logic [DDC_CH-1:0] ddcAddrStb,
    input wire logic [DDC_CH-1:0][SLV_AW-1:0] ddcCalledAddr,
    input wire logic [DDC_CH-1:0][SLV_AW-1:0] ddcOwnAddr,
    input wire logic [DDC_CH-1:0] ddcTxMode,
    input wire logic [DDC_CH-1:0] ddcTxEmpty,
    input wire logic [DDC_CH-1:0] ddcRxWrite,
    input wire logic [DDC_CH-1:0] ddcNak,
    input wire logic [DDC_CH-1:0] ddcStop,
    input wire logic [DDC_CH-1:0] ddcModeRst,
    // Mode back to the DDC engines
    output logic [DDC_CH-1:0] ddc2Mode,
    // Processor request lines
    output logic irqReq,
    output logic nmiReq,
    output logic [15:0] vectorAddr
);

    // Whole block state: one struct, one register
    typedef struct packed {
        logic [NMI_W-1:0] nmiFlag;
        logic [DDC_W-1:0] ddc0Flag;
        logic [DDC_W-1:0] ddc1Flag;
        logic [MISC_W-1:0] miscFlag;
        logic [NMI_W-1:0] nmiEn;
        logic [DDC_W-1:0] ddc0En;
        logic [DDC_W-1:0] ddc1En;
        logic [MISC_W-1:0] miscEn;
        logic [DW-1:0] edgeSel;
        logic [DDC_CH-1:0] ddc2;
        logic irq;
        logic nmi;
        logic [15:0] vec;
        logic [DW-1:0] rdData;
    } tlic_state_t;

    // Reset image of the whole state
    localparam tlic_state_t STATE_RST = '{
        nmiFlag: '0,
        ddc0Flag: '0,
        ddc1Flag: '0,
        miscFlag: '0,
        nmiEn: '0,
        ddc0En: '0,
        ddc1En: '0,
        miscEn: '0,
        edgeSel: EDGE_SEL_RST,
        ddc2: '0,
        irq: 1'b0,
        nmi: 1'b0,
        vec: VEC_IRQ,
        rdData: RD_IDLE
    };

    // Registered state and its next value
    tlic_state_t s_q;
    tlic_state_t s_d;

    // One-cycle edge pulses from the pin detectors
    logic ext0Edge;
    logic ext1Edge;
    logic vsyncEdge;

    // Set wins over a same-cycle write-one clear, so no event is lost
    // Callers widen narrow groups to DW and slice the result back
    function automatic logic [DW-1:0] flagNext(
        input logic [DW-1:0] old,
        input logic [DW-1:0] set,
        input logic [DW-1:0] clr
    );
        flagNext = (old & ~clr) | set;
    endfunction

    // True when some flag of a group is set together with its enable
    function automatic logic anyPending(
        input logic [DW-1:0] flags,
        input logic [DW-1:0] en
    );
        anyPending = |(flags & en);
    endfunction

    // Events of one DDC channel, gated by its mode
    // Nak needs transmit mode only; the engine raises it after a sent byte
    function automatic logic [DDC_W-1:0] ddcSet(
        input logic inDdc2,
        input logic txMode,
        input logic sclLow,
        input logic start,
        input logic addrStb,
        input logic [SLV_AW-1:0] called,
        input logic [SLV_AW-1:0] own,
        input logic txEmpty,
        input logic rxWrite,
        input logic nak,
        input logic stop
    );
        logic [DDC_W-1:0] v;
        v = '0;
        v[DDC_SCL] = ~inDdc2 & (sclLow | start);
        v[DDC_ADDR] = inDdc2 & addrStb & (called == own);
        v[DDC_TX] = inDdc2 & txMode & txEmpty;
        v[DDC_RX] = inDdc2 & ~txMode & rxWrite;
        v[DDC_NAK] = txMode & nak;
        v[DDC_STOP] = inDdc2 & stop;
        ddcSet = v;
    endfunction

    // Edge detectors for the three pin sources
    // Each adds three cycles from pin to pulse; select bits are read live,
    // and changing one while the pin is steady gives no pulse
    tlic_edge_det u_ext0 (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .pinIn(ext0Pin),
        .riseSel(s_q.edgeSel[EDGE_EXT0]),
        .edgePulse(ext0Edge)
    );

    tlic_edge_det u_ext1 (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .pinIn(ext1Pin),
        .riseSel(s_q.edgeSel[EDGE_EXT1]),
        .edgePulse(ext1Edge)
    );

    tlic_edge_det u_vsync (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .pinIn(vsyncPin),
        .riseSel(s_q.edgeSel[EDGE_VSYNC]),
        .edgePulse(vsyncEdge)
    );

    // Next-state logic
    always_comb begin
        logic [DW-1:0] clrNmi;
        logic [DW-1:0] clrDdc0;
        logic [DW-1:0] clrDdc1;
        logic [DW-1:0] clrMisc;
        logic [DW-1:0] setNmi;
        logic [DW-1:0] setDdc0;
        logic [DW-1:0] setDdc1;
        logic [DW-1:0] setMisc;
        logic [DW-1:0] tmp;
        logic [GRP_W-1:0] grp;
        logic anyIrq;
        logic anyNmi;

        s_d = s_q;
        clrNmi = '0;
        clrDdc0 = '0;
        clrDdc1 = '0;
        clrMisc = '0;
        setNmi = '0;
        setMisc = '0;
        tmp = '0;
        setDdc0 = '0;
        setDdc1 = '0;
        grp = '0;
        anyIrq = 1'b0;
        anyNmi = 1'b0;

        // Flags are set by the trigger alone, enables play no part
        // DDC events outside their mode are dropped, not deferred
        setDdc0 = DW'(ddcSet(s_q.ddc2[0], ddcTxMode[0], ddcSclLow[0],
            ddcStart[0], ddcAddrStb[0], ddcCalledAddr[0], ddcOwnAddr[0],
            ddcTxEmpty[0], ddcRxWrite[0], ddcNak[0], ddcStop[0]));
        setDdc1 = DW'(ddcSet(s_q.ddc2[1], ddcTxMode[1], ddcSclLow[1],
            ddcStart[1], ddcAddrStb[1], ddcCalledAddr[1], ddcOwnAddr[1],
            ddcTxEmpty[1], ddcRxWrite[1], ddcNak[1], ddcStop[1]));
        setNmi[NMI_EXT0] = ext0Edge;
        setNmi[NMI_MUTE] = autoMuteEv;
        setMisc[MISC_CONV] = convDoneEv;
        setMisc[MISC_VSYNC] = vsyncEdge;
        setMisc[MISC_EXT1] = ext1Edge;
        setMisc[MISC_TICK] = baseTickEv;

        // Mode switch; a wake event beats a same-cycle return to DDC1
        // The engine owns the bus; this bit only tells it which protocol to expect
        for (int c = 0; c < DDC_CH; c++) begin
            if (~s_q.ddc2[c] & (ddcSclLow[c] | ddcStart[c])) begin
                s_d.ddc2[c] = 1'b1;
            end else if (ddcModeRst[c]) begin
                s_d.ddc2[c] = 1'b0;
            end
        end

        // Register writes: flags clear on one, enables and select store
        // The summary offset is read-only, so a write there matches no branch
        if (busWrStb) begin
            if (busAddr == ADDR_NMI_PEND) begin
                clrNmi = busWrData;
            end else if (busAddr == ADDR_NMI_EN) begin
                s_d.nmiEn = busWrData[NMI_W-1:0];
            end else if (busAddr == ADDR_DDC0_EN) begin
                s_d.ddc0En = busWrData[DDC_W-1:0];
            end else if (busAddr == ADDR_DDC1_EN) begin
                s_d.ddc1En = busWrData[DDC_W-1:0];
            end else if (busAddr == ADDR_MISC_EN) begin
                s_d.miscEn = busWrData[MISC_W-1:0];
            end else if (busAddr == ADDR_DDC0_REQ) begin
                clrDdc0 = busWrData;
            end else if (busAddr == ADDR_DDC1_REQ) begin
                clrDdc1 = busWrData;
            end else if (busAddr == ADDR_MISC_REQ) begin
                clrMisc = busWrData;
            end else if (busAddr == ADDR_EDGE_SEL) begin
                s_d.edgeSel = busWrData;
            end
        end

        // Flag update, hold until a write-one clear
        // Write-ones to reserved bits are dropped by the slice back
        tmp = flagNext(DW'(s_q.nmiFlag), setNmi, clrNmi);
        s_d.nmiFlag = tmp[NMI_W-1:0];
        tmp = flagNext(DW'(s_q.ddc0Flag), setDdc0, clrDdc0);
        s_d.ddc0Flag = tmp[DDC_W-1:0];
        tmp = flagNext(DW'(s_q.ddc1Flag), setDdc1, clrDdc1);
        s_d.ddc1Flag = tmp[DDC_W-1:0];
        tmp = flagNext(DW'(s_q.miscFlag), setMisc, clrMisc);
        s_d.miscFlag = tmp[MISC_W-1:0];

        // Summary bits derive from flags, so they can never go stale
        // Taken from registered flags, so one read sees flags and summary alike
        grp = {|s_q.miscFlag, |s_q.ddc1Flag, |s_q.ddc0Flag};

        // Read data stands only in the cycle after the read strobe
        // Unmapped addresses read as the idle value
        s_d.rdData = RD_IDLE;
        if (busRdStb) begin
            if (busAddr == ADDR_NMI_PEND) begin
                s_d.rdData = DW'(s_q.nmiFlag);
            end else if (busAddr == ADDR_GRP_PEND) begin
                s_d.rdData = DW'(grp);
            end else if (busAddr == ADDR_NMI_EN) begin
                s_d.rdData = DW'(s_q.nmiEn);
            end else if (busAddr == ADDR_DDC0_EN) begin
                s_d.rdData = DW'(s_q.ddc0En);
            end else if (busAddr == ADDR_DDC1_EN) begin
                s_d.rdData = DW'(s_q.ddc1En);
            end else if (busAddr == ADDR_MISC_EN) begin
                s_d.rdData = DW'(s_q.miscEn);
            end else if (busAddr == ADDR_DDC0_REQ) begin
                s_d.rdData = DW'(s_q.ddc0Flag);
            end else if (busAddr == ADDR_DDC1_REQ) begin
                s_d.rdData = DW'(s_q.ddc1Flag);
            end else if (busAddr == ADDR_MISC_REQ) begin
                s_d.rdData = DW'(s_q.miscFlag);
            end else if (busAddr == ADDR_EDGE_SEL) begin
                s_d.rdData = s_q.edgeSel;
            end
        end

        // Request lines from the updated flags and enables
        // Next-state values let a line drop on the edge of the clearing write
        anyIrq = anyPending(DW'(s_d.ddc0Flag), DW'(s_d.ddc0En))
            | anyPending(DW'(s_d.ddc1Flag), DW'(s_d.ddc1En))
            | anyPending(DW'(s_d.miscFlag), DW'(s_d.miscEn));
        anyNmi = anyPending(DW'(s_d.nmiFlag), DW'(s_d.nmiEn));
        s_d.irq = anyIrq;
        s_d.nmi = anyNmi;

        // Vector hint: non-maskable takes precedence in the core
        // The hint cannot steer the core; it only mirrors which line is up
        if (anyNmi) begin
            s_d.vec = VEC_NMI;
        end else begin
            s_d.vec = VEC_IRQ;
        end
    end

    // State register; reset clears every enable
    // Reset acts even while the clock enable is low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= STATE_RST;
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    // All outputs straight from state flip-flops
    // No combinational path runs from any input to any output
    assign busRdData = s_q.rdData;
    assign ddc2Mode = s_q.ddc2;
    assign irqReq = s_q.irq;
    assign nmiReq = s_q.nmi;
    assign vectorAddr = s_q.vec;

endmodule

// ---- core/tlic_pkg.sv ----
// Shared constants of the two-level interrupt collector.
// Assumes an 8-bit register port and one system clock.
package tlic_pkg;

    // Data path and address widths
    localparam int DW = 8;
    localparam int AW = 8;
    localparam int SLV_AW = 7;

    // Source group widths
    localparam int NMI_W = 2;
    localparam int DDC_W = 6;
    localparam int MISC_W = 4;
    localparam int GRP_W = 3;
    localparam int DDC_CH = 2;

    // Register byte offsets
    localparam logic [AW-1:0] ADDR_NMI_PEND = 8'h16;
    localparam logic [AW-1:0] ADDR_GRP_PEND = 8'h17;
    localparam logic [AW-1:0] ADDR_NMI_EN = 8'h18;
    localparam logic [AW-1:0] ADDR_DDC0_EN = 8'h19;
    localparam logic [AW-1:0] ADDR_DDC1_EN = 8'h1a;
    localparam logic [AW-1:0] ADDR_MISC_EN = 8'h1b;
    localparam logic [AW-1:0] ADDR_DDC0_REQ = 8'h1c;
    localparam logic [AW-1:0] ADDR_DDC1_REQ = 8'h1d;
    localparam logic [AW-1:0] ADDR_MISC_REQ = 8'h1e;
    localparam logic [AW-1:0] ADDR_EDGE_SEL = 8'h1f;

    // Non-maskable group bit positions
    localparam int NMI_MUTE = 0;
    localparam int NMI_EXT0 = 1;

    // DDC channel group bit positions
    localparam int DDC_STOP = 0;
    localparam int DDC_NAK = 1;
    localparam int DDC_RX = 2;
    localparam int DDC_TX = 3;
    localparam int DDC_ADDR = 4;
    localparam int DDC_SCL = 5;

    // Miscellaneous group bit positions
    localparam int MISC_TICK = 0;
    localparam int MISC_EXT1 = 1;
    localparam int MISC_VSYNC = 2;
    localparam int MISC_CONV = 3;

    // Edge-select bit positions, a one selects the rising edge
    localparam int EDGE_EXT0 = 0;
    localparam int EDGE_EXT1 = 1;
    localparam int EDGE_VSYNC = 2;

    // Reset values
    localparam logic [DW-1:0] EDGE_SEL_RST = 8'hff;
    localparam logic [DW-1:0] RD_IDLE = 8'h00;

    // Processor vector addresses
    localparam logic [15:0] VEC_NMI = 16'hfffa;
    localparam logic [15:0] VEC_IRQ = 16'hfffe;

endpackage

// ---- core/tlic_edge_det.sv ----
// Pin synchroniser and selectable edge detector.
// Assumes an asynchronous pin and a synchronous active-high reset.
`timescale 1ns/1ps
module tlic_edge_det
    import tlic_pkg::*;
(
    // Clock and control
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // Pin and edge choice
    input wire logic pinIn,
    input wire logic riseSel,
    // One-cycle edge pulse
    output logic edgePulse
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic [1:0] warm;
        logic prev;
        logic primed;
        logic pulse;
    } tlic_edge_st_t;

    localparam tlic_edge_st_t EDGE_RST = '{default: '0};

    tlic_edge_st_t s_q;
    tlic_edge_st_t s_d;

    // Next state: the first stage feeds only the second
    always_comb begin
        s_d = s_q;
        s_d.sync1 = pinIn;
        s_d.sync2 = s_q.sync1;
        s_d.prev = s_q.sync2;
        // Compare only once prev holds a real pin sample, so a pin idling
        // high after reset gives no fake rising edge
        s_d.warm = {s_q.warm[0], 1'b1};
        s_d.primed = s_q.warm[1];
        if (riseSel) begin
            s_d.pulse = s_q.primed & s_q.sync2 & ~s_q.prev;
        end else begin
            s_d.pulse = s_q.primed & ~s_q.sync2 & s_q.prev;
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= EDGE_RST;
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    assign edgePulse = s_q.pulse;

endmodule

// ---- verif/tlic_props.sv ----
// Port checker for the interrupt collector.
// Assumes nothing of clkEn; properties that need a state step name it.
`timescale 1ns/1ps
module tlic_props
    import tlic_pkg::*;
(
    // Watched ports
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [AW-1:0] busAddr,
    input wire logic busRdStb,
    input wire logic [DW-1:0] busRdData,
    input wire logic [DDC_CH-1:0] ddcSclLow,
    input wire logic [DDC_CH-1:0] ddcStart,
    input wire logic [DDC_CH-1:0] ddcModeRst,
    input wire logic [DDC_CH-1:0] ddc2Mode,
    input wire logic irqReq,
    input wire logic nmiReq,
    input wire logic [15:0] vectorAddr
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Taken read of one register
    sequence rdOf(logic [AW-1:0] a);
        busRdStb && clkEn && busAddr == a;
    endsequence
    // Wake request while still in DDC1
    sequence wake0;
        (ddcSclLow[0] || ddcStart[0]) && clkEn && !ddc2Mode[0];
    endsequence
    a_rd_idle: assert property (!busRdStb && clkEn |=> busRdData == RD_IDLE)
        else $error("read data not idle");
    a_nmi_vector: assert property (nmiReq |-> vectorAddr == VEC_NMI)
        else $error("wrong non-maskable vector");
    a_irq_vector: assert property (!nmiReq |-> vectorAddr == VEC_IRQ)
        else $error("wrong maskable vector");
    a_scl_wake: assert property (wake0 |=> ddc2Mode[0])
        else $error("channel did not enter DDC2");
    a_mode_hold: assert property (ddc2Mode[0] && !ddcModeRst[0] |=> ddc2Mode[0])
        else $error("DDC2 mode lost");
    a_mode_back: assert property (ddcModeRst[0] && clkEn && !ddcSclLow[0] && !ddcStart[0] |=> !ddc2Mode[0])
        else $error("mode return ignored");
    a_grp_summary: assert property (rdOf(ADDR_GRP_PEND) ##0 irqReq |=> busRdData[2:0] != 3'h0)
        else $error("request without summary bit");
    a_grp_reserved: assert property (rdOf(ADDR_GRP_PEND) |=> busRdData[7:3] == 5'h00)
        else $error("summary reserved bits set");
    a_nmi_poll: assert property (rdOf(ADDR_NMI_PEND) ##0 nmiReq |=> busRdData[1:0] != 2'h0)
        else $error("non-maskable request without flag");
endmodule
bind tlic_top tlic_props u_props (.clk, .sys_rst, .clkEn, .busAddr, .busRdStb, .busRdData,
    .ddcSclLow, .ddcStart, .ddcModeRst, .ddc2Mode, .irqReq, .nmiReq, .vectorAddr);

// ---- verif/tlic_cpu_model.sv ----
// Processor core stand-in that takes vectors on request lines.
// Assumes level request lines on clk; servicing is left to the bench.
`timescale 1ns/1ps
module tlic_cpu_model
    import tlic_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Request lines and vector
    input wire logic irqReq,
    input wire logic nmiReq,
    input wire logic [15:0] vectorAddr,
    // Last vector fetched and entry count
    output logic [15:0] lastVec,
    output logic [7:0] entries
);
    logic nmiSeen;
    logic irqSeen;
    // Enter once per rising line; a held line means the routine is still busy
    always @(posedge clk) begin
        nmiSeen <= nmiReq;
        irqSeen <= irqReq;
        if (sys_rst) begin
            lastVec <= 16'h0000;
            entries <= 8'h00;
        end else if ((nmiReq && !nmiSeen) || (irqReq && !irqSeen)) begin
            lastVec <= vectorAddr;
            entries <= entries + 8'h01;
        end
    end
endmodule

// ---- verif/tlic_top_tb.sv ----
// Self-checking bench for the interrupt collector.
// Assumes the processor stand-in and the bound port checker.
`timescale 1ns/1ps
module tlic_top_tb
    import tlic_pkg::*;
;
    logic clk = 1'b0;
    logic sysRst, wrStb, rdStb;
    logic [7:0] addr, wdata, rdData;
    // Events: 0 mute, 1 conv, 2 tick, then per kind two channel bits
    logic [18:0] ev;
    logic [2:0] pin;
    logic [1:0] txMode, mode2;
    logic [1:0][6:0] called;
    logic irqReq, nmiReq, clkEn;
    logic [7:0] entries;
    logic [15:0] vec, lastVec;
    int n_fail, n_checks;

    always #2 clk = ~clk;

    tlic_top dut (.clk(clk), .sys_rst(sysRst), .clkEn(clkEn), .busAddr(addr), .busWrData(wdata),
        .busWrStb(wrStb), .busRdStb(rdStb), .busRdData(rdData), .ext0Pin(pin[0]), .ext1Pin(pin[1]),
        .vsyncPin(pin[2]), .autoMuteEv(ev[0]), .convDoneEv(ev[1]), .baseTickEv(ev[2]),
        .ddcSclLow(ev[4:3]), .ddcStart(ev[6:5]), .ddcAddrStb(ev[8:7]), .ddcCalledAddr(called),
        .ddcOwnAddr({7'h51, 7'h50}), .ddcTxMode(txMode), .ddcTxEmpty(ev[10:9]),
        .ddcRxWrite(ev[12:11]), .ddcNak(ev[14:13]), .ddcStop(ev[16:15]), .ddcModeRst(ev[18:17]),
        .ddc2Mode(mode2), .irqReq(irqReq), .nmiReq(nmiReq), .vectorAddr(vec));
    tlic_cpu_model u_cpu (.clk(clk), .sys_rst(sysRst), .irqReq(irqReq), .nmiReq(nmiReq),
        .vectorAddr(vec), .lastVec(lastVec), .entries(entries));

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wrStb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rdStb <= 1'b1;
        addr <= a;
        @(posedge clk);
        rdStb <= 1'b0;
        #1 chk({8'h00, rdData}, {8'h00, e});
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev[k] <= 1'b0;
        #1;
    endtask
    // Pin path is synchroniser plus detector, so allow a few cycles
    task automatic setPin(input int i, input logic v);
        @(posedge clk);
        pin[i] <= v;
        cyc(6);
    endtask

    task automatic t_reset;
        for (int a = 16'h16; a <= 16'h1e; a++) rdc(8'(a), 8'h00);
        rdc(ADDR_EDGE_SEL, 8'hff);
        chk(16'({irqReq, nmiReq, mode2}), 16'h0);
        $display("test reset done");
    endtask
    task automatic t_enable;
        logic [7:0] msk [4] = '{8'h03, 8'h3f, 8'h3f, 8'h0f};
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_NMI_EN + 8'(i), 8'ha5);
            rdc(ADDR_NMI_EN + 8'(i), 8'ha5 & msk[i]);
            wr(ADDR_NMI_EN + 8'(i), 8'h00);
            rdc(ADDR_NMI_EN + 8'(i), 8'h00);
        end
        wr(ADDR_GRP_PEND, 8'hff);
        rdc(ADDR_GRP_PEND, 8'h00);
        rdc(8'h20, 8'h00);
        $display("test enable done");
    endtask
    task automatic t_misc;
        pulse(1);
        pulse(2);
        chk(16'(irqReq), 16'h0);
        rdc(ADDR_MISC_REQ, 8'h09);
        wr(ADDR_MISC_EN, 8'h08);
        cyc(2);
        chk(16'(irqReq), 16'h1);
        rdc(ADDR_GRP_PEND, 8'h04);
        wr(ADDR_MISC_REQ, 8'h01);
        wr(ADDR_MISC_REQ, 8'h00);
        rdc(ADDR_MISC_REQ, 8'h08);
        chk(16'(irqReq), 16'h1);
        wr(ADDR_MISC_REQ, 8'h08);
        rdc(ADDR_GRP_PEND, 8'h00);
        chk(16'(irqReq), 16'h0);
        // An event while the clock enable is low must leave no flag
        @(posedge clk) clkEn <= 1'b0;
        pulse(1);
        @(posedge clk) clkEn <= 1'b1;
        rdc(ADDR_MISC_REQ, 8'h00);
        $display("test misc done");
    endtask
    task automatic t_pins;
        setPin(1, 1'b1);
        setPin(2, 1'b1);
        rdc(ADDR_MISC_REQ, 8'h06);
        wr(ADDR_MISC_REQ, 8'h06);
        wr(ADDR_EDGE_SEL, 8'hf9);
        rdc(ADDR_EDGE_SEL, 8'hf9);
        setPin(1, 1'b0);
        setPin(2, 1'b0);
        rdc(ADDR_MISC_REQ, 8'h06);
        wr(ADDR_MISC_REQ, 8'h06);
        setPin(1, 1'b1);
        setPin(2, 1'b1);
        rdc(ADDR_MISC_REQ, 8'h00);
        wr(ADDR_EDGE_SEL, 8'hff);
        $display("test pins done");
    endtask
    task automatic t_nmi;
        int n;
        logic [7:0] e0;
        wr(ADDR_NMI_EN, 8'h02);
        e0 = entries;
        @(posedge clk);
        pin[0] <= 1'b1;
        for (n = 0; n < 20 && nmiReq !== 1'b1; n++) cyc(1);
        if (n == 20) begin
            chk(16'(nmiReq), 16'h1);
            summarize;
        end
        // The core stand-in takes the vector one edge after the line rises
        cyc(1);
        chk(lastVec, VEC_NMI);
        chk(16'(entries), 16'(e0 + 8'h01));
        pulse(0);
        rdc(ADDR_NMI_PEND, 8'h03);
        wr(ADDR_NMI_PEND, 8'h02);
        cyc(2);
        chk(16'(nmiReq), 16'h0);
        rdc(ADDR_NMI_PEND, 8'h01);
        wr(ADDR_NMI_PEND, 8'h01);
        rdc(ADDR_NMI_PEND, 8'h00);
        $display("test nmi done");
    endtask
    task automatic t_ddc(input int ch);
        logic [7:0] a;
        a = ADDR_DDC0_REQ + 8'(ch);
        pulse(15 + ch);
        pulse(3 + ch);
        chk(16'(mode2[ch]), 16'h1);
        @(posedge clk) called[ch] <= 7'h22;
        pulse(7 + ch);
        rdc(a, 8'h20);
        @(posedge clk) called[ch] <= 7'h50 + 7'(ch);
        pulse(7 + ch);
        @(posedge clk) txMode[ch] <= 1'b1;
        pulse(9 + ch);
        pulse(13 + ch);
        @(posedge clk) txMode[ch] <= 1'b0;
        pulse(11 + ch);
        pulse(15 + ch);
        rdc(a, 8'h3f);
        rdc(ADDR_GRP_PEND, 8'h01 << ch);
        wr(a, 8'h3f);
        rdc(a, 8'h00);
        pulse(17 + ch);
        chk(16'(mode2[ch]), 16'h0);
        // A start condition wakes the channel as well
        pulse(5 + ch);
        chk(16'(mode2[ch]), 16'h1);
        rdc(a, 8'h20);
        wr(a, 8'h20);
        rdc(a, 8'h00);
        $display("test ddc channel %0d done", ch);
    endtask

    initial begin
        n_fail = 0;
        n_checks = 0;
        sysRst = 1'b1;
        wrStb = 1'b0;
        rdStb = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        ev = '0;
        pin = '0;
        txMode = '0;
        clkEn = 1'b1;
        called = '0;
        repeat (12) @(posedge clk);
        sysRst <= 1'b0;
        t_reset;
        t_enable;
        t_misc;
        t_pins;
        t_nmi;
        t_ddc(0);
        t_ddc(1);
        summarize;
    end
endmodule
